//--- core/usdb_data_buffer.sv
// Serial port data buffer: shared data location, transmit hand-off,
// receive FIFO, flags, interrupt and register port
//
// Contract
// RL1 - One data location: writes go to the transmit holding buffer, reads return the receive FIFO head.
// RL2 - Short characters drop the unused upper bits on transmit and read them as zero on receive.
// RL3 - A data write is taken only while the transmit-empty flag is set, otherwise discarded.
// RL4 - With the transmitter enabled, held data moves into an empty shift register and is sent on txd.
// RL5 - The receive holding buffer is a two-deep FIFO and every data read advances it.
// RL6 - Software avoids bit set/clear and takes care with bit tests on the data location.
// RL7 - The receive-complete flag in status A bit 7 is high exactly while the FIFO holds data.
// RL8 - Disabling the receiver flushes the FIFO so the receive-complete flag reads zero.
// RL9 - The receive-complete flag, gated by its enable, requests an interrupt.
// RL10 - The transmit-empty flag is set after reset.
// RL11 - Overrun is flagged when the FIFO is full, a character waits and a new start bit comes.
// RL12 - Software reads the ninth received bit before the low eight bits.
// RL13 - The double-speed bit shortens a bit from 16 to 8 baud ticks.
// RL14 - A taken write clears the transmit-empty flag until the data reaches the shift register.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module usdb_data_buffer #(
   parameter int FIFO_DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [usdb_pkg::ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Serial lines
   output logic txd,
   input wire logic rxd,
   // Interrupt
   output logic irq
);
   import usdb_pkg::*;
   // Refused at elaboration: the overrun logic assumes exactly two slots
   if (FIFO_DEPTH != 2) begin : g_badDepth
      $error("usdb_data_buffer: FIFO_DEPTH must be 2");
   end

   // ==========================================================
   // Declarations
   usdb_rx_if #(.WIDTH(9)) rxq ();
   logic dbl_q, rxcie_q, rxEn_q, txEn_q, tx9_q;
   logic [2:0] size_q;
   logic [11:0] baud_q, baudCnt_q;
   logic [2:0] irqStat_q, irqEn_q;
   logic txFull_q, overrun_q;
   logic [8:0] txHold_q, txShift_q, rxShift_q, rxWait_q;
   logic rxWaitValid_q;
   logic [3:0] txPhase_q, txBit_q, rxPhase_q, rxBit_q;
   usdb_tx_state_type txState_q;
   usdb_rx_state_type rxState_q;
   logic [7:0] regRdata_d;
   logic txd_d;

   // ==========================================================
   // Address decode
   wire selData = (regAddr == OFS_DATA);
   wire wrData = regWr && selData;
   wire rdData = regRd && selData; // [RL1]
   wire wrStatA = regWr && (regAddr == OFS_STAT_A);
   wire wrCtrlB = regWr && (regAddr == OFS_CTRL_B);
   wire wrCtrlC = regWr && (regAddr == OFS_CTRL_C);
   wire wrBaudL = regWr && (regAddr == OFS_BAUD_L);
   wire wrBaudH = regWr && (regAddr == OFS_BAUD_H);
   wire wrIrqClr = regWr && (regAddr == OFS_IRQ_CLR);
   wire wrIrqEn = regWr && (regAddr == OFS_IRQ_EN);

   // ==========================================================
   // Baud timing
   wire baudTick = (baudCnt_q == baud_q);
   wire [3:0] bitLast = dbl_q ? LAST_DOUBLE : LAST_NORMAL; // [RL13]
   wire [3:0] bitMid = dbl_q ? MID_DOUBLE : MID_NORMAL; // [RL13]
   wire [3:0] nBits = usdb_bits(size_q);
   wire [8:0] sizeMask = usdb_mask(size_q);
   wire txBitEnd = baudTick && (txPhase_q == bitLast);
   wire rxBitEnd = baudTick && (rxPhase_q == bitLast);
   wire rxMid = baudTick && (rxPhase_q == bitMid);

   // Divider free-runs so both directions share one tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) baudCnt_q <= '0;
      else baudCnt_q <= baudTick ? 12'h000 : baudCnt_q + 12'h001;
   end

   // ==========================================================
   // Transmit holding buffer and hand-off
   wire txEmpty = !txFull_q;
   wire txTake = wrData && txEmpty; // [RL3]
   wire txLoad = txFull_q && txEn_q && (txState_q == TX_IDLE); // [RL4]

   // Take is tested first; a load never meets it in one cycle, since a write
   // there is refused anyway by the full flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txFull_q <= RST_TX_FULL; // [RL10]
         txHold_q <= '0;
      end else if (txTake) begin
         txFull_q <= 1'b1; // [RL14]
         txHold_q <= {tx9_q, regWdata} & sizeMask; // [RL2]
      end else if (txLoad) begin
         txFull_q <= 1'b0; // [RL14]
      end
   end

   // ==========================================================
   // Transmit shift register: start, data LSB first, one stop bit.
   // A frame under way always finishes even if the enable drops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txState_q <= TX_IDLE;
         txShift_q <= '0;
         txPhase_q <= '0;
         txBit_q <= '0;
      end else begin
         if (txState_q == TX_IDLE) txPhase_q <= '0;
         else if (baudTick) txPhase_q <= txBitEnd ? 4'h0 : txPhase_q + 4'h1;
         case (txState_q)
            TX_IDLE: begin
               if (txLoad) begin
                  txShift_q <= txHold_q; // [RL4]
                  txState_q <= TX_START;
               end
            end
            TX_START: begin
               txBit_q <= '0;
               if (txBitEnd) txState_q <= TX_DATA;
            end
            TX_DATA: begin
               if (txBitEnd) begin
                  txShift_q <= {1'b0, txShift_q[8:1]};
                  txBit_q <= txBit_q + 4'h1;
                  if (txBit_q == nBits - 4'h1) txState_q <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (txBitEnd) txState_q <= TX_IDLE;
            end
            default: txState_q <= TX_IDLE;
         endcase
      end
   end

   // Line level; idle high
   assign txd_d = (txState_q == TX_START) ? 1'b0 :
                  (txState_q == TX_DATA) ? txShift_q[0] : 1'b1;

   // ==========================================================
   // Receive shift register
   wire rxStart = rxEn_q && (rxState_q == RX_IDLE) && !rxd;
   wire rxDone = (rxState_q == RX_STOP) && rxMid;
   wire [8:0] rxAligned = rxShift_q >> (4'h9 - nBits);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxState_q <= RX_IDLE;
         rxShift_q <= '0;
         rxPhase_q <= '0;
         rxBit_q <= '0;
      end else if (!rxEn_q) begin
         rxState_q <= RX_IDLE;
         rxPhase_q <= '0;
      end else begin
         if (rxState_q == RX_IDLE) rxPhase_q <= '0;
         else if (baudTick) rxPhase_q <= rxBitEnd ? 4'h0 : rxPhase_q + 4'h1;
         case (rxState_q)
            RX_IDLE: begin
               rxBit_q <= '0;
               if (rxStart) rxState_q <= RX_START;
            end
            RX_START: begin
               // A glitch shorter than half a bit is no start
               if (rxMid && rxd) rxState_q <= RX_IDLE;
               else if (rxBitEnd) rxState_q <= RX_DATA;
            end
            RX_DATA: begin
               if (rxMid) rxShift_q <= {rxd, rxShift_q[8:1]};
               if (rxBitEnd) begin
                  rxBit_q <= rxBit_q + 4'h1;
                  if (rxBit_q == nBits - 4'h1) rxState_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               // Back to idle at mid stop so a new start is caught
               if (rxMid) rxState_q <= RX_IDLE;
            end
            default: rxState_q <= RX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Waiting character, FIFO and overrun
   wire overrunEv = rxStart && rxq.full && rxWaitValid_q; // [RL11]
   assign rxq.push = rxWaitValid_q && !rxq.full && rxEn_q;
   assign rxq.pushData = rxWait_q;
   assign rxq.pop = rdData; // [RL5]
   assign rxq.flush = !rxEn_q; // [RL8]

   // A character that finds the waiting slot taken replaces it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxWaitValid_q <= 1'b0;
         rxWait_q <= '0;
      end else if (!rxEn_q) begin
         rxWaitValid_q <= 1'b0; // [RL8]
      end else if (rxDone) begin
         rxWaitValid_q <= 1'b1;
         rxWait_q <= rxAligned & sizeMask; // [RL2]
      end else if (rxq.push) begin
         rxWaitValid_q <= 1'b0;
      end
   end

   // Overrun lives until the data location is read or the receiver is disabled; a new event wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) overrun_q <= 1'b0;
      else if (overrunEv) overrun_q <= 1'b1; // [RL11]
      else if (rdData || !rxEn_q) overrun_q <= 1'b0;
   end

   usdb_rx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .rx(rxq)
   );

   // ==========================================================
   // Control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dbl_q <= 1'b0;
         rxcie_q <= 1'b0;
         rxEn_q <= 1'b0;
         txEn_q <= 1'b0;
         tx9_q <= 1'b0;
         size_q <= RST_SIZE;
         baud_q <= RST_BAUD;
         irqEn_q <= '0;
      end else begin
         if (wrStatA) dbl_q <= regWdata[B_DBL];
         if (wrCtrlB) begin
            rxcie_q <= regWdata[B_RXCIE];
            rxEn_q <= regWdata[B_RXEN];
            txEn_q <= regWdata[B_TXEN];
            size_q[2] <= regWdata[B_SIZE2];
            tx9_q <= regWdata[B_TX9];
         end
         if (wrCtrlC) size_q[1:0] <= regWdata[2:1];
         if (wrBaudL) baud_q[7:0] <= regWdata;
         if (wrBaudH) baud_q[11:8] <= regWdata[3:0];
         if (wrIrqEn) irqEn_q <= regWdata[2:0];
      end
   end

   // ==========================================================
   // Sticky events and interrupt; set wins over a clear
   wire rxComplete = !rxq.empty; // [RL7]
   wire [2:0] events = {overrunEv, txLoad, rxq.push};
   wire [2:0] irqClr = wrIrqClr ? regWdata[2:0] : 3'h0;
   wire [2:0] irqStat_d = (irqStat_q & ~irqClr) | events;
   wire irq_d = (|(irqStat_d & irqEn_q)) || (rxComplete && rxcie_q); // [RL9]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_q <= '0;
         irq <= 1'b0;
         txd <= 1'b1;
      end else begin
         irqStat_q <= irqStat_d;
         irq <= irq_d;
         txd <= txd_d;
      end
   end

   // ==========================================================
   // Read data; unmapped and write-only locations read zero.
   // FIFO storage has no reset, so an empty FIFO reads as zero.
   wire [8:0] rxHead = rxq.empty ? 9'h000 : rxq.headData;
   always_comb begin
      regRdata_d = 8'h00;
      if (selData) begin
         regRdata_d = rxHead[7:0]; // [RL1]
      end else if (regAddr == OFS_STAT_A) begin
         regRdata_d[B_RXC] = rxComplete; // [RL7]
         regRdata_d[B_TXE] = txEmpty;
         regRdata_d[B_OVR] = overrun_q;
         regRdata_d[B_DBL] = dbl_q;
      end else if (regAddr == OFS_CTRL_B) begin
         regRdata_d = {rxcie_q, 2'b00, rxEn_q, txEn_q, size_q[2],
                       rxHead[8], tx9_q};
      end else if (regAddr == OFS_CTRL_C) begin
         regRdata_d = {5'h00, size_q[1:0], 1'b0};
      end else if (regAddr == OFS_BAUD_L) begin
         regRdata_d = baud_q[7:0];
      end else if (regAddr == OFS_BAUD_H) begin
         regRdata_d = {4'h0, baud_q[11:8]};
      end else if (regAddr == OFS_IRQ_STAT) begin
         regRdata_d = {5'h00, irqStat_q};
      end else if (regAddr == OFS_IRQ_EN) begin
         regRdata_d = {5'h00, irqEn_q};
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) regRdata <= 8'h00;
      else regRdata <= regRd ? regRdata_d : 8'h00;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence seqDataWrBusy;
      wrData && txFull_q;
   endsequence
   sequence seqDataRdHit;
      rdData && !rxq.empty && !rxq.push && rxEn_q;
   endsequence
   AST_WRITE_REFUSED: assert property (seqDataWrBusy |=> // [RL3]
      txHold_q == $past(txHold_q)) else $error("busy write changed hold");
   AST_WRITE_TAKEN: assert property (wrData && txEmpty |=> // [RL14]
      txFull_q && !txEmpty ##0 txState_q != TX_IDLE || txFull_q)
      else $error("taken write left buffer empty");
   AST_HANDOFF: assert property (txLoad |=> // [RL4]
      txState_q == TX_START && txShift_q == $past(txHold_q) ##1 !txd)
      else $error("hand-off did not start frame");
   AST_RXC_READ: assert property (regRd && regAddr == OFS_STAT_A |=> // [RL7]
      regRdata[B_RXC] == !$past(rxq.empty)) else $error("rxc flag wrong");
   AST_POP: assert property (seqDataRdHit ##1 !rxq.push |-> // [RL5]
      rxq.full == 1'b0) else $error("read did not advance fifo");
   AST_FLUSH: assert property (!rxEn_q |=> rxq.empty && // [RL8]
      !rxWaitValid_q) else $error("disable did not flush");
   AST_IRQ_RXC: assert property (rxComplete && rxcie_q |=> irq) // [RL9]
      else $error("rx complete gave no interrupt");
   AST_UPPER_ZERO: assert property (rxq.push |-> // [RL2]
      (rxq.pushData & ~sizeMask) == 9'h000) else $error("upper bits set");
   AST_OVERRUN: assert property (overrunEv |=> overrun_q [*1] ##0 // [RL11]
      irqStat_q[B_EV_OVR]) else $error("overrun not flagged");
   AST_DOUBLE: assert property (txState_q == TX_START && txBitEnd |-> // [RL13]
      txPhase_q == (dbl_q ? 4'h7 : 4'hf)) else $error("bit length wrong");
   AST_DATA_READ: assert property (regRd && selData |=> // [RL1]
      regRdata == $past(rxHead[7:0])) else $error("data read wrong");
endmodule : usdb_data_buffer

//--- core/usdb_pkg.sv
// Constants, register map and types of the serial data buffer block
package usdb_pkg;
   // ==========================================================
   // Register offsets
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_DATA = 4'h0;
   localparam logic [3:0] OFS_STAT_A = 4'h1;
   localparam logic [3:0] OFS_CTRL_B = 4'h2;
   localparam logic [3:0] OFS_CTRL_C = 4'h3;
   localparam logic [3:0] OFS_BAUD_L = 4'h4;
   localparam logic [3:0] OFS_BAUD_H = 4'h5;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
   localparam logic [3:0] OFS_IRQ_CLR = 4'h7;
   localparam logic [3:0] OFS_IRQ_EN = 4'h8;
   // ==========================================================
   // Field positions
   localparam int B_RXC = 7;
   localparam int B_TXE = 5;
   localparam int B_OVR = 3;
   localparam int B_DBL = 1;
   localparam int B_RXCIE = 7;
   localparam int B_RXEN = 4;
   localparam int B_TXEN = 3;
   localparam int B_SIZE2 = 2;
   localparam int B_RX9 = 1;
   localparam int B_TX9 = 0;
   localparam int B_EV_RX = 0;
   localparam int B_EV_TX = 1;
   localparam int B_EV_OVR = 2;
   // ==========================================================
   // Reset values
   localparam logic [2:0] RST_SIZE = 3'h3;
   localparam logic [11:0] RST_BAUD = 12'h000;
   localparam logic RST_TX_FULL = 1'b0;
   // ==========================================================
   // Timing: last tick of a bit and the mid-bit sample tick
   localparam logic [3:0] LAST_NORMAL = 4'hf;
   localparam logic [3:0] LAST_DOUBLE = 4'h7;
   localparam logic [3:0] MID_NORMAL = 4'h7;
   localparam logic [3:0] MID_DOUBLE = 4'h3;
   // ==========================================================
   // State machines
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
   } usdb_tx_state_type;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
   } usdb_rx_state_type;
   // Data bits of a character from the size code
   function automatic logic [3:0] usdb_bits(input logic [2:0] code);
      usdb_bits = (code == 3'h7) ? 4'h9 : {2'b01, code[1:0]} + 4'h1;
   endfunction : usdb_bits
   // Mask that keeps only the bits of a character
   function automatic logic [8:0] usdb_mask(input logic [2:0] code);
      usdb_mask = ~(9'h1ff << usdb_bits(code));
   endfunction : usdb_mask
endpackage : usdb_pkg

//--- core/usdb_rx_if.sv
// Interface between the receive logic and its holding FIFO
`timescale 1ns/1ps
interface usdb_rx_if #(parameter int WIDTH = 9);
   logic push;
   logic [WIDTH-1:0] pushData;
   logic pop;
   logic flush;
   logic [WIDTH-1:0] headData;
   logic empty;
   logic full;
   modport store (input push, pushData, pop, flush,
                  output headData, empty, full);
   modport user (output push, pushData, pop, flush,
                 input headData, empty, full);
endinterface : usdb_rx_if

//--- core/usdb_rx_fifo.sv
// Receive holding FIFO
`timescale 1ns/1ps
module usdb_rx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // FIFO side of the receive interface
   usdb_rx_if.store rx
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   localparam logic [CW-1:0] CNT_MAX = CW'(DEPTH);
   // Pointers wrap by overflow, so the depth must be a power of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_badParams
      $error("usdb_rx_fifo: DEPTH must be a power of two >= 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [CW-1:0] count_q;
   wire doPush = rx.push && (count_q != CNT_MAX);
   wire doPop = rx.pop && (count_q != '0);
   assign rx.empty = (count_q == '0);
   assign rx.full = (count_q == CNT_MAX);
   assign rx.headData = mem[rdPtr_q];
   // Pointers and fill level; flush empties at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else if (rx.flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_q + PW'(doPush);
         rdPtr_q <= rdPtr_q + PW'(doPop);
         if (doPush && !doPop) count_q <= count_q + CNT_ONE;
         else if (doPop && !doPush) count_q <= count_q - CNT_ONE;
      end
   end
   // Storage needs no reset; an empty FIFO is never read as valid
   always_ff @(posedge clk) begin
      if (doPush) mem[wrPtr_q] <= rx.pushData;
   end
endmodule : usdb_rx_fifo

//--- sim/usdb_serial_peer.sv
// Remote serial transceiver model facing the data buffer's serial lines
`timescale 1ns/1ps
module usdb_serial_peer (
   // Bench clock
   input wire logic clk,
   // Serial lines
   input wire logic txd,
   output logic rxd,
   // Frame shape: data bits and clocks per bit
   input wire logic [3:0] nBits,
   input wire logic [4:0] bitLen
);
   logic [8:0] got;
   logic stopSeen;
   int count;
   // ==========================================================
   // Capture
   // Idle line is high, as a pulled-up serial input would be
   initial begin
      rxd = 1'b1;
      count = 0;
      got = 9'h000;
      stopSeen = 1'b0;
   end
   // Sample mid bit; a wrong bit length on txd shows as a bad char
   always begin : capture
      @(negedge txd);
      got = 9'h000;
      repeat (bitLen / 2) @(posedge clk);
      for (int i = 0; i < nBits; i++) begin
         repeat (bitLen) @(posedge clk);
         got[i] = txd;
      end
      repeat (bitLen) @(posedge clk);
      stopSeen = txd;
      count++;
   end
   // ==========================================================
   // Transmit one frame: start, nBits data LSB first, one stop
   task automatic send(input logic [8:0] ch);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (bitLen) @(posedge clk);
      for (int i = 0; i < nBits; i++) begin
         rxd <= ch[i];
         repeat (bitLen) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (bitLen) @(posedge clk);
   endtask : send
endmodule : usdb_serial_peer

//--- sim/usdb_data_buffer_tb.sv
// Self-checking bench of the serial data buffer
`timescale 1ns/1ps
module usdb_data_buffer_tb;
   import usdb_pkg::*;
   logic clk, rst_n, regWr, regRd, txd, rxd, irq;
   logic [ADDR_W-1:0] regAddr;
   logic [7:0] regWdata, regRdata, v;
   logic [3:0] nBits;
   logic [4:0] bitLen;
   int n_errors, compares;
   // ==========================================================
   // Clock, reset, design and far side
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   usdb_data_buffer #(.FIFO_DEPTH(2)) i_dut (.clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .txd(txd), .rxd(rxd),
      .irq(irq));
   usdb_serial_peer i_peer (.clk(clk), .txd(txd), .rxd(rxd),
      .nBits(nBits), .bitLen(bitLen));
   // ==========================================================
   // Bus and check tasks
   task automatic chk(input string name, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   // One-cycle write; each call starts on a fresh edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   task automatic waitTx(input int n);
      for (int k = 0; k < 4000 && i_peer.count < n; k++) @(posedge clk);
      chk("frames", n[7:0], i_peer.count[7:0]);
   endtask : waitTx
   task automatic irqIs(input logic e);
      repeat (3) @(posedge clk);
      chk("irq", {7'h00, e}, {7'h00, irq});
   endtask : irqIs
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd(OFS_STAT_A, v);
      chk("status after reset", 8'h20, v);
      rd(4'hf, v);
      chk("unmapped", 8'h00, v);
      chk("irq after reset", 8'h00, {7'h00, irq});
   endtask : t_reset
   // Four chars without reads: two in FIFO, one waiting, one overruns
   task automatic t_rxFifo;
      wr(OFS_CTRL_B, 8'h10);
      i_peer.send(9'h011);
      irqIs(1'b0);
      wr(OFS_CTRL_B, 8'h90);
      irqIs(1'b1);
      i_peer.send(9'h022);
      i_peer.send(9'h033);
      i_peer.send(9'h044);
      rd(OFS_STAT_A, v);
      chk("status full", 8'ha8, v);
      rd(OFS_DATA, v);
      chk("fifo head 1", 8'h11, v);
      rd(OFS_DATA, v);
      chk("fifo head 2", 8'h22, v);
      wr(OFS_CTRL_B, 8'h80);
      rd(OFS_STAT_A, v);
      chk("status flushed", 8'h20, v);
      irqIs(1'b0);
      rd(OFS_IRQ_STAT, v);
      chk("irq events", 8'h05, v);
      wr(OFS_IRQ_EN, 8'h01);
      irqIs(1'b1);
      wr(OFS_IRQ_CLR, 8'h07);
      irqIs(1'b0);
      wr(OFS_IRQ_EN, 8'h00);
   endtask : t_rxFifo
   // Write held while disabled, second write refused, then hand-off
   task automatic t_txHold;
      int n;
      n = i_peer.count;
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_DATA, 8'ha5);
      rd(OFS_STAT_A, v);
      chk("status held", 8'h00, v);
      wr(OFS_DATA, 8'h3c);
      wr(OFS_CTRL_B, 8'h08);
      waitTx(n + 1);
      chk("tx char", 8'ha5, i_peer.got[7:0]);
      repeat (400) @(posedge clk);
      chk("refused write", n[7:0] + 8'h01, i_peer.count[7:0]);
      rd(OFS_STAT_A, v);
      chk("status idle", 8'h20, v);
   endtask : t_txHold
   // Seven-bit characters both ways
   task automatic t_short;
      int n;
      n = i_peer.count;
      nBits = 4'h7;
      wr(OFS_CTRL_C, 8'h04);
      wr(OFS_CTRL_B, 8'h18);
      i_peer.send(9'h055);
      rd(OFS_DATA, v);
      chk("rx 7 bit", 8'h55, v);
      wr(OFS_DATA, 8'hff);
      waitTx(n + 1);
      chk("tx 7 bit", 8'h7f, i_peer.got[7:0]);
      chk("tx stop", 8'h01, {7'h00, i_peer.stopSeen});
   endtask : t_short
   // Nine-bit characters: ninth bit read before the data, sent with it
   task automatic t_nine;
      int n;
      n = i_peer.count;
      nBits = 4'h9;
      wr(OFS_CTRL_C, 8'h06);
      wr(OFS_CTRL_B, 8'h1c);
      i_peer.send(9'h1a5);
      rd(OFS_CTRL_B, v);
      chk("rx ninth bit", 8'h1e, v);
      rd(OFS_DATA, v);
      chk("rx 9 bit low", 8'ha5, v);
      wr(OFS_CTRL_B, 8'h1d);
      wr(OFS_DATA, 8'h3c);
      waitTx(n + 1);
      chk("tx 9 bit low", 8'h3c, i_peer.got[7:0]);
      chk("tx ninth bit", 8'h01, {7'h00, i_peer.got[8]});
      wr(OFS_CTRL_B, 8'h18);
   endtask : t_nine
   // Half-length bits with double speed
   task automatic t_double;
      int n;
      n = i_peer.count;
      nBits = 4'h8;
      wr(OFS_CTRL_C, 8'h06);
      wr(OFS_STAT_A, 8'h02);
      bitLen = 5'd8;
      wr(OFS_DATA, 8'h96);
      waitTx(n + 1);
      chk("tx double", 8'h96, i_peer.got[7:0]);
   endtask : t_double
   // Reset in mid-frame: line, interrupt and status back to reset state
   task automatic t_midReset;
      wr(OFS_IRQ_EN, 8'h02);
      irqIs(1'b1);
      wr(OFS_DATA, 8'h5a);
      repeat (20) @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("txd in reset", 8'h01, {7'h00, txd});
      chk("irq in reset", 8'h00, {7'h00, irq});
      rst_n <= 1'b1;
      rd(OFS_STAT_A, v);
      chk("status after mid reset", 8'h20, v);
      irqIs(1'b0);
      // Let the peer finish the cut frame before the verdict
      repeat (100) @(posedge clk);
   endtask : t_midReset
   // ==========================================================
   // Verdict, the single end of the run
   task automatic conclude;
      $display("checks %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   // Watchdog: the whole run needs well under 20000 cycles
   initial begin
      #100us;
      n_errors++;
      conclude();
   end
   // Main sequence
   initial begin
      n_errors = 0;
      compares = 0;
      rst_n = 1'b0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      nBits = 4'h8;
      bitLen = 5'd16;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_rxFifo();
      t_txHold();
      t_short();
      t_nine();
      t_double();
      t_midReset();
      conclude();
   end
endmodule : usdb_data_buffer_tb
